// ===== inc/acr_pkg.sv
// acr package: register map, field layout, codes and carrier types
// Functional notes
// - With the mode pin high, the pin function field picks power-down, standby, run with outputs off or run with outputs on.
// - The sample rate is the input clock divided by the low three bits of the divider field plus one.
// - A nonzero test code replaces converted samples with test data, and code zero restores normal data.
// - Codes 1 to 4 give midscale, positive full scale, negative full scale and an alternating checkerboard.
// - Code 5 gives a pseudo-random sequence of order 23 and code 6 one of order 9.
// - Code 7 toggles the whole word between ones and zeros and code 9 toggles single bits.
// - Code 8 gives the user pattern words, 10 a sync word, 11 a single high bit and 12 mixed bit frequencies.
// - The eight-bit trim is added to the converted code as a signed twos complement number.
// - The format field codes the output as offset binary (00 or 11), twos complement (01) or gray code (10).
// - Written values wait in a shadow stage and take effect only when the host sets the transfer bit.
package acr_pkg;
  localparam int          DW          = 14;
  localparam int          SIG_W       = 16;
  localparam int          INST_BITS   = 16;
  localparam int          DATA_BITS   = 8;
  localparam int          RD_BIT      = 15;
  localparam logic [12:0] ADR_PWR     = 13'h008;
  localparam logic [12:0] ADR_DIV     = 13'h00B;
  localparam logic [12:0] ADR_TST     = 13'h00D;
  localparam logic [12:0] ADR_BIST    = 13'h00E;
  localparam logic [12:0] ADR_OFFS    = 13'h010;
  localparam logic [12:0] ADR_FMT     = 13'h014;
  localparam logic [12:0] ADR_DRV     = 13'h015;
  localparam logic [12:0] ADR_XFER    = 13'h0FF;
  localparam logic [7:0]  RST_PWR     = 8'h00;
  localparam logic [7:0]  RST_DIV     = 8'h00;
  localparam logic [7:0]  RST_TST     = 8'h00;
  localparam logic [7:0]  RST_BIST    = 8'h00;
  localparam logic [7:0]  RST_OFFS    = 8'h00;
  localparam logic [7:0]  RST_FMT     = 8'h00;
  localparam logic [7:0]  RST_DRV     = 8'h22;
  localparam int          F_CHIP      = 0;
  localparam int          F_PINFN     = 5;
  localparam int          F_XFER      = 0;
  localparam int          F_PNS       = 4;
  localparam int          F_PNL       = 5;
  localparam int          F_BIST_EN   = 0;
  localparam int          F_BIST_INIT = 2;
  localparam int          F_INV       = 2;
  localparam int          F_DIS       = 4;
  localparam int          F_VOLT      = 6;
  localparam logic [1:0]  FMT_TWOS    = 2'h1;
  localparam logic [1:0]  FMT_GRAY    = 2'h2;
  localparam logic [DW-1:0] DAT_MIN   = 14'h0000;
  localparam logic [DW-1:0] DAT_MAX   = 14'h3FFF;
  localparam logic [DW-1:0] PAT_MID   = 14'h2000;
  localparam logic [DW-1:0] PAT_CHK   = 14'h2AAA;
  localparam logic [DW-1:0] PAT_SYNC  = 14'h3F80;
  localparam logic [DW-1:0] PAT_ONE   = 14'h0001;
  localparam logic [22:0] PN23_SEED   = 23'h7FFFFF;
  localparam logic [8:0]  PN9_SEED    = 9'h1FF;
  localparam logic [SIG_W-1:0] SIG_INIT = 16'h0000;

  typedef enum logic [3:0] {
    TP_OFF = 4'h0, TP_MID = 4'h1, TP_PFS = 4'h2, TP_NFS = 4'h3,
    TP_CHK = 4'h4, TP_PN23 = 4'h5, TP_PN9 = 4'h6, TP_WTOG = 4'h7,
    TP_USER = 4'h8, TP_BTOG = 4'h9, TP_SYNC = 4'hA, TP_ONE = 4'hB,
    TP_MIX = 4'hC
  } acr_tp_t;

  typedef enum logic [1:0] {
    PW_DOWN = 2'h0, PW_STBY = 2'h1, PW_NOUT = 2'h2, PW_RUN = 2'h3
  } acr_pwr_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'h0, SP_INST = 2'h1, SP_DATA = 2'h3, SP_DONE = 2'h2
  } acr_spi_t;

  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] div;
    logic [7:0] tst;
    logic [7:0] bist;
    logic [7:0] offs;
    logic [7:0] fmt;
    logic [7:0] drv;
  } acr_cfg_t;

  typedef struct packed {
    logic csb_n;
    logic sclk;
    logic sdio;
    logic mode;
  } acr_pins_t;

  localparam acr_cfg_t CFG_RST =
    '{RST_PWR, RST_DIV, RST_TST, RST_BIST, RST_OFFS, RST_FMT, RST_DRV};
  localparam acr_pins_t PINS_RST = '{csb_n: 1'b1, sclk: 1'b0, sdio: 1'b0, mode: 1'b0};

  function automatic acr_cfg_t acr_cfg_wr(input acr_cfg_t c, input logic [12:0] a,
                                          input logic [7:0] d);
    acr_cfg_t r;
    r = c;
    case (a)
      ADR_PWR:  r.pwr  = d;
      ADR_DIV:  r.div  = d;
      ADR_TST:  r.tst  = d;
      ADR_BIST: r.bist = d;
      ADR_OFFS: r.offs = d;
      ADR_FMT:  r.fmt  = d;
      ADR_DRV:  r.drv  = d;
      default:  r      = c;
    endcase
    return r;
  endfunction : acr_cfg_wr

  function automatic logic [7:0] acr_cfg_rd(input acr_cfg_t c, input logic [12:0] a);
    case (a)
      ADR_PWR:  return c.pwr;
      ADR_DIV:  return c.div;
      ADR_TST:  return c.tst;
      ADR_BIST: return c.bist;
      ADR_OFFS: return c.offs;
      ADR_FMT:  return c.fmt;
      ADR_DRV:  return c.drv;
      default:  return 8'h00;
    endcase
  endfunction : acr_cfg_rd

  function automatic logic [DW-1:0] acr_trim(input logic [DW-1:0] v, input logic [7:0] t);
    logic signed [15:0] s;
    s = $signed({2'b00, v}) + $signed({{8{t[7]}}, t});
    if (s < 16'sh0000) return DAT_MIN;
    if (s > $signed({2'b00, DAT_MAX})) return DAT_MAX;
    return s[DW-1:0];
  endfunction : acr_trim

  function automatic logic [DW-1:0] acr_fmt(input logic [DW-1:0] v, input logic [1:0] f);
    case (f)
      FMT_TWOS: return {~v[DW-1], v[DW-2:0]};
      FMT_GRAY: return v ^ (v >> 1);
      default:  return v;
    endcase
  endfunction : acr_fmt
endpackage : acr_pkg

// ===== verilog/acr_tpg.sv
// acr test pattern generator
`timescale 1ns/1ps
module acr_tpg
  import acr_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          tick_i,
  input  wire logic [3:0]    code_i,
  input  wire logic          rst_long_i,
  input  wire logic          rst_short_i,
  input  wire logic [DW-1:0] patt1_i,
  input  wire logic [DW-1:0] patt2_i,
  output logic      [DW-1:0] word_o
);
  logic          tog_q;
  logic [22:0]   pn23_q;
  logic [8:0]    pn9_q;
  logic [DW-1:0] walk_q;
  logic [DW-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tog_q  <= 1'b0;
      pn23_q <= PN23_SEED;
      pn9_q  <= PN9_SEED;
      walk_q <= PAT_ONE;
      cnt_q  <= DAT_MIN;
    end
    else
    begin
      if (tick_i)
      begin
        tog_q  <= ~tog_q;
        walk_q <= {walk_q[DW-2:0], walk_q[DW-1]};
        cnt_q  <= cnt_q + PAT_ONE;
      end
      if (rst_long_i)
        pn23_q <= PN23_SEED;
      else if (tick_i && code_i == TP_PN23)
        pn23_q <= {pn23_q[21:0], pn23_q[22] ^ pn23_q[17]};
      if (rst_short_i)
        pn9_q <= PN9_SEED;
      else if (tick_i && code_i == TP_PN9)
        pn9_q <= {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
    end
  end

  always_comb
  begin
    case (code_i)
      TP_MID:  word_o = PAT_MID;
      TP_PFS:  word_o = DAT_MAX;
      TP_NFS:  word_o = DAT_MIN;
      TP_CHK:  word_o = tog_q ? ~PAT_CHK : PAT_CHK;
      TP_PN23: word_o = pn23_q[DW-1:0];
      TP_PN9:  word_o = {pn9_q, pn9_q[8:4]};
      TP_WTOG: word_o = tog_q ? DAT_MAX : DAT_MIN;
      TP_USER: word_o = tog_q ? patt2_i : patt1_i;
      TP_BTOG: word_o = walk_q;
      TP_SYNC: word_o = PAT_SYNC;
      TP_ONE:  word_o = PAT_ONE;
      TP_MIX:  word_o = cnt_q;
      default: word_o = DAT_MIN;
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_PN9_STEP: assert property ((tick_i && code_i == TP_PN9 && !rst_short_i)
    ##1 (code_i == TP_PN9) |-> word_o != $past(word_o))
    else $error("pn9 sequence did not advance");
  AST_WORD_TOG: assert property ((tick_i && code_i == TP_WTOG)
    ##1 (code_i == TP_WTOG) |-> word_o == ~$past(word_o))
    else $error("word toggle did not invert");
  AST_USER_ALT: assert property ((tick_i && code_i == TP_USER && word_o == patt1_i)
    ##1 (code_i == TP_USER) |-> word_o == patt2_i)
    else $error("user pattern did not alternate");
endmodule : acr_tpg

// ===== verilog/acr_top.sv
// acr configuration register bank with serial port and sample path
`timescale 1ns/1ps
module acr_top
  import acr_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             csb_n_i,
  input  wire logic             sclk_i,
  input  wire logic             sdio_i,
  input  wire logic             mode_i,
  input  wire logic [DW-1:0]    adc_data_i,
  input  wire logic [DW-1:0]    user_patt1_i,
  input  wire logic [DW-1:0]    user_patt2_i,
  output logic                  sdio_o,
  output logic                  sdio_oe_n_o,
  output logic      [DW-1:0]    data_o,
  output logic                  data_oe_n_o,
  output logic                  dco_o,
  output logic      [1:0]       pwr_state_o,
  output logic      [1:0]       out_volt_o,
  output logic      [7:0]       drive_o,
  output logic      [SIG_W-1:0] bist_sig_o
);
  // pin synchronisers
  acr_pins_t raw_w;
  acr_pins_t s1_q;
  acr_pins_t s2_q;
  acr_pins_t s3_q;
  acr_pins_t pin_q;
  acr_pins_t pin_d;
  acr_pins_t diff_w;

  // serial port
  acr_spi_t          st_q;
  acr_spi_t          st_d;
  logic [4:0]        cnt_q;
  logic [INST_BITS-1:0] inst_q;
  logic [INST_BITS-1:0] inst_nx_w;
  logic [7:0]        dsh_q;
  logic [7:0]        rsh_q;
  logic [7:0]        wr_byte_w;
  logic [7:0]        rd_byte_w;
  logic [12:0]       addr_w;
  logic              sclk_prev_q;
  logic              sel_w;
  logic              rise_w;
  logic              fall_w;
  logic              is_rd_w;
  logic              inst_end_w;
  logic              wr_done_w;
  logic              xfer_w;
  logic              pend_w;

  // configuration
  acr_cfg_t          shd_q;
  acr_cfg_t          act_q;

  // power and divider
  acr_pwr_t          pwr_w;
  logic [1:0]        pin_fn_w;
  logic [1:0]        chip_w;
  logic              dig_rst_w;
  logic              tick_en_w;
  logic              tick_w;
  logic              out_en_w;
  logic [2:0]        dcnt_q;
  logic [2:0]        dcnt_d;

  // sample path
  logic [DW-1:0]     tpg_w;
  logic [DW-1:0]     trim_w;
  logic [DW-1:0]     word_w;
  logic [DW-1:0]     fmtd_w;
  logic [DW-1:0]     fin_w;
  logic [SIG_W-1:0]  sig_d;

  // three stages, change taken when stages two and three agree
  assign raw_w  = '{csb_n: csb_n_i, sclk: sclk_i, sdio: sdio_i, mode: mode_i};
  assign diff_w = s2_q ^ s3_q;
  assign pin_d  = (s3_q & ~diff_w) | (pin_q & diff_w);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_q  <= PINS_RST;
      s2_q  <= PINS_RST;
      s3_q  <= PINS_RST;
      pin_q <= PINS_RST;
    end
    else
    begin
      s1_q  <= raw_w;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end

  // serial frame decode
  assign sel_w      = ~pin_q.csb_n;
  assign rise_w     = sel_w & pin_q.sclk & ~sclk_prev_q;
  assign fall_w     = sel_w & ~pin_q.sclk & sclk_prev_q;
  assign inst_nx_w  = {inst_q[INST_BITS-2:0], pin_q.sdio};
  assign is_rd_w    = inst_q[RD_BIT];
  assign addr_w     = inst_q[12:0];
  assign inst_end_w = rise_w && (st_q == SP_INST) && (cnt_q == 5'(INST_BITS - 1));
  assign wr_byte_w  = {dsh_q[6:0], pin_q.sdio};
  assign wr_done_w  = rise_w && (st_q == SP_DATA) && !is_rd_w
                      && (cnt_q == 5'(DATA_BITS - 1));
  assign xfer_w     = wr_done_w && (addr_w == ADR_XFER) && wr_byte_w[F_XFER];
  assign pend_w     = (shd_q != act_q);
  assign rd_byte_w  = (inst_nx_w[12:0] == ADR_XFER) ? {7'h00, pend_w}
                      : acr_cfg_rd(shd_q, inst_nx_w[12:0]);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SP_IDLE: if (sel_w) st_d = SP_INST;
      SP_INST: if (inst_end_w) st_d = SP_DATA;
      SP_DATA: if (rise_w && cnt_q == 5'(DATA_BITS - 1)) st_d = SP_DONE;
      SP_DONE: st_d = SP_DONE;
      default: st_d = SP_IDLE;
    endcase
    if (!sel_w)
      st_d = SP_IDLE;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q        <= SP_IDLE;
      cnt_q       <= 5'h00;
      inst_q      <= 16'h0000;
      dsh_q       <= 8'h00;
      rsh_q       <= 8'h00;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      sclk_prev_q <= pin_q.sclk;
      if (st_q != st_d)
        cnt_q <= 5'h00;
      else if (rise_w)
        cnt_q <= cnt_q + 5'h01;
      if (rise_w && st_q == SP_INST)
        inst_q <= inst_nx_w;
      if (rise_w && st_q == SP_DATA)
        dsh_q <= wr_byte_w;
      if (inst_end_w)
        rsh_q <= rd_byte_w;
      else if (fall_w && st_q == SP_DATA)
        rsh_q <= {rsh_q[6:0], 1'b0};
    end
  end

  // read data goes out on falling edges of the serial clock
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sdio_o      <= 1'b0;
      sdio_oe_n_o <= 1'b1;
    end
    else if (st_q != SP_DATA || !is_rd_w)
    begin
      sdio_o      <= 1'b0;
      sdio_oe_n_o <= 1'b1;
    end
    else if (fall_w)
    begin
      sdio_o      <= rsh_q[7];
      sdio_oe_n_o <= 1'b0;
    end
  end

  // shadow and active configuration
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shd_q <= CFG_RST;
      act_q <= CFG_RST;
    end
    else
    begin
      if (wr_done_w)
        shd_q <= acr_cfg_wr(shd_q, addr_w, wr_byte_w);
      if (xfer_w)
        act_q <= shd_q;
    end
  end

  // power state from mode pin or chip field
  assign pin_fn_w  = act_q.pwr[F_PINFN +: 2];
  assign chip_w    = act_q.pwr[F_CHIP +: 2];
  assign dig_rst_w = !pin_q.mode && (chip_w == 2'h3);
  assign pwr_w     = pin_q.mode ? acr_pwr_t'(pin_fn_w)
                   : (chip_w == 2'h1) ? PW_DOWN
                   : (chip_w == 2'h2) ? PW_STBY : PW_RUN;
  assign tick_en_w = pwr_state_o[1] && !dig_rst_w;
  assign out_en_w  = (pwr_state_o == PW_RUN) && !act_q.fmt[F_DIS];

  // sample divider
  assign tick_w = tick_en_w && (dcnt_q == act_q.div[2:0]);
  assign dcnt_d = (!tick_en_w || tick_w) ? 3'h0 : dcnt_q + 3'h1;

  // sample word selection and coding
  assign trim_w = acr_trim(adc_data_i, act_q.offs);
  assign word_w = (act_q.tst[3:0] != TP_OFF) ? tpg_w : trim_w;
  assign fmtd_w = acr_fmt(word_w, act_q.fmt[1:0]);
  assign fin_w  = act_q.fmt[F_INV] ? ~fmtd_w : fmtd_w;
  assign sig_d  = {bist_sig_o[SIG_W-2:0],
                   bist_sig_o[15] ^ bist_sig_o[14] ^ bist_sig_o[12] ^ bist_sig_o[3]}
                  ^ {2'b00, fin_w};

  acr_tpg u_tpg (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .tick_i      (tick_w),
    .code_i      (act_q.tst[3:0]),
    .rst_long_i  (act_q.tst[F_PNL]),
    .rst_short_i (act_q.tst[F_PNS]),
    .patt1_i     (user_patt1_i),
    .patt2_i     (user_patt2_i),
    .word_o      (tpg_w)
  );

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dcnt_q      <= 3'h0;
      pwr_state_o <= PW_DOWN;
      dco_o       <= 1'b0;
      drive_o     <= RST_DRV;
      out_volt_o  <= 2'h0;
    end
    else
    begin
      dcnt_q      <= dcnt_d;
      pwr_state_o <= pwr_w;
      dco_o       <= tick_w;
      drive_o     <= act_q.drv;
      out_volt_o  <= act_q.fmt[F_VOLT +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      data_o      <= DAT_MIN;
      data_oe_n_o <= 1'b1;
    end
    else
    begin
      data_oe_n_o <= !out_en_w;
      if (!out_en_w)
        data_o <= DAT_MIN;
      else if (tick_w)
        data_o <= fin_w;
    end
  end

  // self-test signature
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bist_sig_o <= SIG_INIT;
    else if (act_q.bist[F_BIST_INIT])
      bist_sig_o <= SIG_INIT;
    else if (act_q.bist[F_BIST_EN] && tick_w)
      bist_sig_o <= sig_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_div1_start;
    tick_w && act_q.div[2:0] == 3'h1 && !xfer_w;
  endsequence
  sequence s_run2;
    (tick_en_w && !xfer_w) ##1 tick_en_w;
  endsequence
  sequence s_plain(logic [3:0] c, logic [1:0] f);
    tick_w && act_q.tst[3:0] == c && act_q.fmt[1:0] == f && !act_q.fmt[F_INV] && out_en_w;
  endsequence

  AST_PIN_PD: assert property ((pin_q.mode && pin_fn_w == 2'h0) |=> pwr_state_o == PW_DOWN)
    else $error("mode pin did not power down");
  AST_PIN_STBY: assert property ((pin_q.mode && pin_fn_w == 2'h1)
    |=> pwr_state_o == PW_STBY ##1 !dco_o)
    else $error("mode pin standby not honoured");
  AST_DIV2: assert property (s_div1_start ##1 s_run2 |-> tick_w && !$past(tick_w))
    else $error("divide by two spacing wrong");
  AST_MID: assert property (s_plain(4'h1, 2'h0) |=> data_o == PAT_MID)
    else $error("midscale pattern wrong");
  AST_TWOS_PFS: assert property (s_plain(4'h2, FMT_TWOS) |=> data_o == 14'h1FFF)
    else $error("twos complement full scale wrong");
  AST_TRIM: assert property (s_plain(4'h0, 2'h0) |=> data_o == $past(trim_w))
    else $error("offset trim not applied");
  AST_SHADOW: assert property (!xfer_w |=> act_q == $past(act_q))
    else $error("active config changed without transfer");
  AST_XFER: assert property (xfer_w |=> act_q == $past(shd_q) && !pend_w)
    else $error("transfer did not copy shadow");
  AST_OFF: assert property (act_q.fmt[F_DIS] |=> data_oe_n_o && data_o == DAT_MIN)
    else $error("disabled outputs still active");
  AST_INIT: assert property (act_q.bist[F_BIST_INIT] |=> bist_sig_o == SIG_INIT)
    else $error("signature not cleared");
endmodule : acr_top

// ===== sim/acr_host.sv
// host controller model for the serial control port
`timescale 1ns/1ps
module acr_host
  import acr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sdio_i,
  input  wire logic sdio_oe_n_i,
  output logic      csb_n_o,
  output logic      sclk_o,
  output logic      sdio_o
);
  logic drv_q;
  logic bit_q;
  // released line shows the inverse of the last bit
  assign sdio_o = !sdio_oe_n_i ? sdio_i : (drv_q ? bit_q : ~bit_q);
  initial
  begin
    csb_n_o = 1'b1;
    sclk_o  = 1'b0;
    drv_q   = 1'b0;
    bit_q   = 1'b0;
  end
  task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {r, 2'b00, a, d};
    q = 8'h00;
    @(posedge clk_i);
    #1 csb_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    for (int i = 23; i >= 0; i--)
    begin
      #1 sclk_o = 1'b0;
      drv_q = !(r && i < 8);
      bit_q = f[i];
      repeat (6) @(posedge clk_i);
      if (i < 8) q[i] = sdio_o;
      #1 sclk_o = 1'b1;
      repeat (6) @(posedge clk_i);
    end
    #1 sclk_o = 1'b0;
    drv_q = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 csb_n_o = 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : xfer
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [12:0] a, output logic [7:0] q);
    xfer(1'b1, a, 8'h00, q);
  endtask : rd
  task automatic apply();
    wr(ADR_XFER, 8'h01);
  endtask : apply
endmodule : acr_host

// ===== sim/tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_top
  import acr_pkg::*;
;
  logic             clk_i = 1'b0;
  logic             nrst_i;
  logic             csb_n, sclk, sdio, mode_i, sdio_o, sdio_oe_n_o, data_oe_n_o, dco_o;
  logic [DW-1:0]    adc_data_i, patt1, patt2, data_o;
  logic [1:0]       pwr_state_o, out_volt_o;
  logic [7:0]       drive_o, r;
  logic [SIG_W-1:0] bist_sig_o;
  logic [31:0]      seed = 32'h0d1e;
  logic [DW-1:0]    exp_q[$];
  int               fail_count = 0;
  int               n_tests = 0;
  int               cyc = 0;
  localparam logic [12:0] ADRS[7] = '{ADR_PWR, ADR_DIV, ADR_TST, ADR_BIST, ADR_OFFS,
                                      ADR_FMT, ADR_DRV};
  localparam logic [7:0]  RSTS[7] = '{RST_PWR, RST_DIV, RST_TST, RST_BIST, RST_OFFS,
                                      RST_FMT, RST_DRV};
  localparam logic [3:0]  CODES[5] = '{4'h1, 4'h2, 4'h3, 4'hB, 4'hA};
  localparam logic [DW-1:0] WORDS[5] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h0001, 14'h3F80};

  acr_top u_acr_top (.clk_i(clk_i), .nrst_i(nrst_i), .csb_n_i(csb_n), .sclk_i(sclk),
    .sdio_i(sdio), .mode_i(mode_i), .adc_data_i(adc_data_i), .user_patt1_i(patt1),
    .user_patt2_i(patt2), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .dco_o(dco_o), .pwr_state_o(pwr_state_o),
    .out_volt_o(out_volt_o), .drive_o(drive_o), .bist_sig_o(bist_sig_o));
  acr_host u_acr_host (.clk_i(clk_i), .sdio_i(sdio_o), .sdio_oe_n_i(sdio_oe_n_o),
    .csb_n_o(csb_n), .sclk_o(sclk), .sdio_o(sdio));

  always #20 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 45000)
    begin
      fail_count++;
      final_report();
    end
  end

  // compares each new sample word with the oldest expectation
  always @(negedge clk_i)
    if (dco_o === 1'b1 && exp_q.size() > 0) check(data_o, exp_q.pop_front());

  task automatic cfg(input logic [12:0] a, input logic [7:0] d);
    u_acr_host.wr(a, d);
    u_acr_host.apply();
    repeat (10) @(posedge clk_i);
  endtask : cfg

  task automatic expect_word(input logic [DW-1:0] v);
    repeat (6) @(posedge clk_i);
    exp_q.push_back(v);
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge clk_i);
    if (exp_q.size() > 0) check(1'b0, 1'b1);
    exp_q.delete();
  endtask : expect_word

  // two consecutive sample words must be the pair, in either order
  task automatic expect_pair(input logic [3:0] c, input logic [DW-1:0] a,
                             input logic [DW-1:0] b);
    logic [DW-1:0] w;
    cfg(ADR_TST, {4'h0, c});
    @(negedge clk_i);
    w = data_o;
    @(negedge clk_i);
    check({w, data_o}, (w == a) ? {a, b} : {b, a});
  endtask : expect_pair

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone

  initial
  begin
    int n;
    logic [DW-1:0] v;
    nrst_i = 1'b0;
    mode_i = 1'b0;
    adc_data_i = 14'h1234;
    patt1 = DW'(rnd());
    patt2 = DW'(rnd());
    repeat (10) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    foreach (ADRS[i])
    begin
      u_acr_host.rd(ADRS[i], r);
      check(r, RSTS[i]);
    end
    u_acr_host.rd(13'h020, r);
    check(r, 8'h00);
    check(drive_o, 8'h22);
    tdone("reset");
    foreach (ADRS[i])
    begin
      v = DW'(rnd());
      u_acr_host.wr(ADRS[i], v[7:0]);
      u_acr_host.rd(ADRS[i], r);
      check(r, v[7:0]);
      u_acr_host.wr(ADRS[i], RSTS[i]);
    end
    tdone("shadow rw");
    u_acr_host.wr(ADR_TST, 8'h01);
    expect_word(14'h1234);
    u_acr_host.rd(ADR_XFER, r);
    check(r, 8'h01);
    u_acr_host.apply();
    expect_word(PAT_MID);
    foreach (CODES[i])
    begin
      cfg(ADR_TST, {4'h0, CODES[i]});
      expect_word(WORDS[i]);
    end
    expect_pair(4'h4, PAT_CHK, ~PAT_CHK);
    expect_pair(4'h7, DAT_MAX, DAT_MIN);
    expect_pair(4'h8, patt1, patt2);
    cfg(ADR_TST, 8'h06);
    tdone("patterns");
    cfg(ADR_TST, 8'h01);
    cfg(ADR_FMT, 8'h01);
    expect_word(14'h0000);
    cfg(ADR_TST, 8'h02);
    expect_word(14'h1FFF);
    cfg(ADR_TST, 8'h01);
    cfg(ADR_FMT, 8'h02);
    expect_word(14'h3000);
    cfg(ADR_FMT, 8'h03);
    expect_word(14'h2000);
    cfg(ADR_FMT, 8'h04);
    expect_word(14'h1FFF);
    cfg(ADR_FMT, 8'h10);
    check({data_oe_n_o, data_o}, {1'b1, 14'h0000});
    cfg(ADR_FMT, 8'hC0);
    check({data_oe_n_o, out_volt_o}, {1'b0, 2'h3});
    tdone("format");
    cfg(ADR_TST, 8'h00);
    cfg(ADR_FMT, 8'h00);
    v = (DW'(rnd()) & 14'h0FFF) | 14'h1000;
    #1 adc_data_i = v;
    cfg(ADR_OFFS, 8'h05);
    expect_word(v + 14'h0005);
    #1 adc_data_i = 14'h0010;
    cfg(ADR_OFFS, 8'h80);
    expect_word(14'h0000);
    #1 adc_data_i = 14'h3FF0;
    cfg(ADR_OFFS, 8'h20);
    expect_word(14'h3FFF);
    cfg(ADR_OFFS, 8'h00);
    tdone("trim");
    for (int d = 0; d < 4; d += (d == 1) ? 2 : 1)
    begin
      cfg(ADR_DIV, d[7:0]);
      n = 0;
      for (int i = 0; i < 20 && dco_o !== 1'b1; i++) @(negedge clk_i);
      @(negedge clk_i);
      for (n = 1; n < 20 && dco_o !== 1'b1; n++) @(negedge clk_i);
      check(n, d + 1);
    end
    cfg(ADR_DIV, 8'h00);
    tdone("divider");
    v = DW'(rnd());
    cfg(ADR_DRV, v[7:0]);
    check(drive_o, v[7:0]);
    cfg(ADR_BIST, 8'h04);
    check(bist_sig_o, SIG_INIT);
    cfg(ADR_TST, 8'h01);
    cfg(ADR_BIST, 8'h01);
    repeat (20) @(posedge clk_i);
    check(bist_sig_o != SIG_INIT, 1'b1);
    tdone("drive and self-test");
    #1 mode_i = 1'b1;
    for (int f = 3; f >= 0; f--)
    begin
      cfg(ADR_PWR, 8'(f << 5));
      check({pwr_state_o, data_oe_n_o}, {f[1:0], f != 3});
    end
    #1 mode_i = 1'b0;
    cfg(ADR_PWR, 8'h01);
    check(pwr_state_o, PW_DOWN);
    cfg(ADR_PWR, 8'h03);
    check({pwr_state_o, dco_o}, {PW_RUN, 1'b0});
    tdone("mode pin");
    final_report();
  end
endmodule : tb_top
